// ---- verilog/tbps_pin_share.sv ----
// Contract
// - The first shared pin is the channel 0 add-bus bit when bus 0 is enabled, else the channel 8 line clock.
// - With bus 0 enabled the pin is captured on every falling edge of the bus 0 clock.
// - That captured bit is bit 7, the most significant bit, of each channel 0 add byte.
// - With bus 0 disabled the shared pin is the channel 8 line clock that samples the channel 8 line data.
// - By default channel 8 line data is captured on the falling line clock edge.
// - In DS3/E3 mode with the invert bit set the line data is captured on the rising edge instead.
// - In STS-1 mode the line data is always captured on the falling edge.
// - The second shared pin is the channel 1 add-bus input when bus 1 is enabled, else a general output.
// - With bus 1 enabled the pin is captured on every falling edge of the bus 1 clock.
// - With bus 1 disabled the second pin is driven as the loop request output.
// - The loop request output follows the loop request bit of the channel 1 drive register.
module tbps_pin_share (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Register port
	input wire tbps_pkg::tbps_cpu_req_t cpu_req,
	output logic [7:0] cpu_rdata,
	output logic cpu_rvalid,
	// Configuration levels from the framer
	input wire logic bus0_enable,
	input wire logic bus1_enable,
	input wire logic ch8_sts1_mode,
	// Shared pin A24 and companions
	input wire logic pin_a_in,
	input wire logic add_bus0_clock,
	input wire logic [6:0] add_bus0_low_bits,
	input wire logic line_data_in_ch8,
	// Shared pin C25 and companions
	input wire logic pin_b_in,
	output logic pin_b_out,
	output logic pin_b_oe,
	input wire logic add_bus1_clock,
	input wire logic [7:1] add_bus1_high_bits,
	// Captured results
	output logic [7:0] add_bus0_byte,
	output logic [7:0] add_bus1_byte,
	output logic line_bit_ch8,
	output logic bus_enable0_sync,
	output logic bus_enable1_sync
);

	// ==========================================================
	// Decode helpers
	function automatic logic f_hit(input logic [15:0] addr,
		input logic [15:0] target);
		return addr == target;
	endfunction

	// ==========================================================
	// Register file on the system clock
	tbps_pkg::tbps_sys_state_t st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rvalid = 1'b0;
		if (cpu_req.wr) begin
			if (f_hit(cpu_req.addr, tbps_pkg::LINE_DRIVE_CH1_ADDR)) begin
				nxt_st.line_drive_ch1 = cpu_req.wdata;
			end
			if (f_hit(cpu_req.addr, tbps_pkg::IO_CONTROL_CH8_ADDR)) begin
				nxt_st.io_control_ch8 = cpu_req.wdata;
			end
		end
		if (cpu_req.rd) begin
			nxt_st.rvalid = 1'b1;
			case (cpu_req.addr)
				tbps_pkg::LINE_DRIVE_CH1_ADDR: begin
					nxt_st.rdata = st_ff.line_drive_ch1;
				end
				tbps_pkg::IO_CONTROL_CH8_ADDR: begin
					nxt_st.rdata = st_ff.io_control_ch8;
				end
				default: begin
					nxt_st.rdata = 8'h00;
				end
			endcase
		end
		// Enables may come from another domain, so resynchronise
		nxt_st.bus_en_s1 = {bus1_enable, bus0_enable};
		nxt_st.bus_en_s2 = st_ff.bus_en_s1;
		nxt_st.mode_s1 = {ch8_sts1_mode,
			st_ff.io_control_ch8[tbps_pkg::LINE_CLOCK_INVERT_POS],
			bus0_enable};
		nxt_st.mode_s2 = st_ff.mode_s1;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '{line_drive_ch1: tbps_pkg::LINE_DRIVE_CH1_RST,
				io_control_ch8: tbps_pkg::IO_CONTROL_CH8_RST,
				rdata: 8'h00, rvalid: 1'b0, bus_en_s1: 2'h0,
				bus_en_s2: 2'h0, mode_s1: 3'h0, mode_s2: 3'h0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cpu_rdata = st_ff.rdata;
	assign cpu_rvalid = st_ff.rvalid;
	assign bus_enable0_sync = st_ff.bus_en_s2[0];
	assign bus_enable1_sync = st_ff.bus_en_s2[1];

	// ==========================================================
	// Second pin: output only while bus 1 is off
	assign pin_b_oe = ~st_ff.bus_en_s2[1];
	// Register bit is held, so the pin only moves after a write
	assign pin_b_out =
		st_ff.line_drive_ch1[tbps_pkg::LOOP_REQUEST_POS];

	// ==========================================================
	// Channel 0 add bus, falling edge of its own clock
	logic [7:0] add0_ff;

	always_ff @(negedge add_bus0_clock or negedge arst_n) begin
		if (!arst_n) begin
			add0_ff <= 8'h00;
		end else begin
			add0_ff <= {pin_a_in, add_bus0_low_bits};
		end
	end

	assign add_bus0_byte = add0_ff;

	// ==========================================================
	// Channel 1 add bus, falling edge of its own clock
	logic [7:0] add1_ff;

	always_ff @(negedge add_bus1_clock or negedge arst_n) begin
		if (!arst_n) begin
			add1_ff <= 8'h00;
		end else if (!pin_b_oe) begin
			// Pin is ours to drive otherwise; never latch our own level
			add1_ff <= {add_bus1_high_bits, pin_b_in};
		end
	end

	assign add_bus1_byte = add1_ff;

	// ==========================================================
	// Channel 8 line data, clocked by the shared pin itself
	// Mode bits are quasi-static; a change takes effect after the
	// line clock has run a few edges, so reconfigure while idle.
	logic [1:0] line_mode_s1_ff;
	logic [1:0] line_mode_s2_ff;
	logic line_fall_ff;
	logic line_rise_ff;
	logic use_rise;

	always_ff @(negedge pin_a_in or negedge arst_n) begin
		if (!arst_n) begin
			line_mode_s1_ff <= 2'h0;
			line_mode_s2_ff <= 2'h0;
			line_fall_ff <= 1'b0;
		end else begin
			line_mode_s1_ff <= {st_ff.mode_s2[tbps_pkg::MODE_STS1_POS],
				st_ff.mode_s2[tbps_pkg::MODE_INV_POS]};
			line_mode_s2_ff <= line_mode_s1_ff;
			line_fall_ff <= line_data_in_ch8;
		end
	end

	always_ff @(posedge pin_a_in or negedge arst_n) begin
		if (!arst_n) begin
			line_rise_ff <= 1'b0;
		end else begin
			line_rise_ff <= line_data_in_ch8;
		end
	end

	// Rising edge only for DS3/E3 with invert set; STS-1 forces falling
	assign use_rise = line_mode_s2_ff[0] & ~line_mode_s2_ff[1];
	// Shared pin is a line clock only while bus 0 is off
	assign line_bit_ch8 = st_ff.mode_s2[tbps_pkg::MODE_BUS0_POS] ? 1'b0 :
		(use_rise ? line_rise_ff : line_fall_ff);

endmodule

// ---- verilog/tbps_pkg.sv ----
package tbps_pkg;

	// ==========================================================
	// Register map (direct byte addresses)
	localparam logic [15:0] LINE_DRIVE_CH1_ADDR = 16'h2F80;
	localparam logic [15:0] IO_CONTROL_CH8_ADDR = 16'h9F01;
	localparam logic [7:0] LINE_DRIVE_CH1_RST = 8'h00;
	localparam logic [7:0] IO_CONTROL_CH8_RST = 8'h00;

	// ==========================================================
	// Field positions
	localparam int LOOP_REQUEST_POS = 1;
	localparam int LINE_CLOCK_INVERT_POS = 1;
	localparam int ADD_BUS_MSB_POS = 7;
	localparam int ADD_BUS_LSB_POS = 0;

	// ==========================================================
	// Grouped signals
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tbps_cpu_req_t;

	typedef struct packed {
		logic [7:0] line_drive_ch1;
		logic [7:0] io_control_ch8;
		logic [7:0] rdata;
		logic rvalid;
		logic [1:0] bus_en_s1;
		logic [1:0] bus_en_s2;
		logic [2:0] mode_s1;
		logic [2:0] mode_s2;
	} tbps_sys_state_t;

	// Mode bits passed to the line domain: {sts1, invert, bus0_en}
	localparam int MODE_BUS0_POS = 0;
	localparam int MODE_INV_POS = 1;
	localparam int MODE_STS1_POS = 2;

endpackage

// ---- verification/tbps_chk.sv ----
module tbps_chk (
	input wire logic clk_sys, arst_n, pin_a_in, pin_b_in, pin_b_out,
	input wire logic pin_b_oe, bus1_enable, bus_enable0_sync, line_bit_ch8,
	input wire logic add_bus0_clock, add_bus1_clock, cpu_rvalid,
	input wire tbps_pkg::tbps_cpu_req_t cpu_req,
	input wire logic [7:0] cpu_rdata, add_bus0_byte, add_bus1_byte
);
	// ======
	// Checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	wire wr1 = cpu_req.wr && cpu_req.addr == tbps_pkg::LINE_DRIVE_CH1_ADDR;
	a_oe_off: assert property (bus1_enable[*3] |-> !pin_b_oe)
		else $error("pin still driven");
	a_oe_on: assert property (!bus1_enable[*3] |-> pin_b_oe)
		else $error("pin not driven");
	a_loop_set: assert property (wr1 |=> pin_b_out == $past(cpu_req.wdata[1]))
		else $error("loop level wrong");
	a_loop_hold: assert property (!wr1 |=> $stable(pin_b_out))
		else $error("loop level moved");
	a_rd_answer: assert property (cpu_req.rd |=> cpu_rvalid)
		else $error("no read answer");
	a_line_mute: assert property (bus_enable0_sync[*2] |-> !line_bit_ch8)
		else $error("line bit while bus on");
	a_msb_take: assert property (@(negedge add_bus0_clock) bus_enable0_sync
		|=> add_bus0_byte[7] == $past(pin_a_in)) else $error("msb wrong");
	a_lsb_take: assert property (@(negedge add_bus1_clock) !pin_b_oe
		|=> add_bus1_byte[0] == $past(pin_b_in)) else $error("lsb wrong");
	cover property (wr1);
	cover property (cpu_rvalid);
	cover property (bus_enable0_sync ##1 !bus_enable0_sync);
endmodule

// ---- verification/tbps_liu.sv ----
module tbps_liu (
	output logic lclk,
	output logic ldata
);
	timeunit 1ns;
	timeprecision 100ps;
	// ======
	// Recovered clock, free running, off the system clock grid
	initial begin
		lclk = 1'b0;
		#0.5;
		forever #3 lclk = ~lclk;
	end
	// Falling edges see 1, rising edges 0: the chosen edge shows
	always @(lclk) ldata <= #1 lclk;
endmodule

// ---- verification/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0, arst_n = 1'b0, b0 = 1'b0, b1 = 1'b0, sts = 1'b0;
	tbps_pkg::tbps_cpu_req_t req = '0;
	logic [7:0] d0 = 8'h00, d1 = 8'h00, rdata, by0, by1, v;
	logic lclk, ldata, pb_out, pb_oe, lbit, rv;
	logic [7:0] rq[$];
	int mismatches = 0, check_count = 0, seed = 32'h10245b13, i;
	`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
		mismatches++; $display("[ERR] %0t %h %h", $time, a, e); end end
	always #20 clk_sys = ~clk_sys;
	tbps_liu u_liu (.lclk(lclk), .ldata(ldata));
	tbps_pin_share u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .cpu_req(req),
		.cpu_rdata(rdata), .cpu_rvalid(rv), .bus0_enable(b0),
		.bus1_enable(b1), .ch8_sts1_mode(sts), .pin_a_in(b0 ? d0[7] : lclk),
		.add_bus0_clock(lclk), .add_bus0_low_bits(d0[6:0]),
		.line_data_in_ch8(ldata),
		.pin_b_in(pb_oe ? pb_out : d1[0]),
		.pin_b_out(pb_out), .pin_b_oe(pb_oe), .add_bus1_clock(lclk),
		.add_bus1_high_bits(d1[7:1]), .add_bus0_byte(by0),
		.add_bus1_byte(by1), .line_bit_ch8(lbit), .bus_enable0_sync(),
		.bus_enable1_sync());
	// Idle cycle after each access keeps req to one assignment per edge
	task automatic cyc(input logic w, r, input logic [15:0] a,
		input logic [7:0] d);
		req <= '{a, d, w, r};
		@(posedge clk_sys);
		req <= '0;
		@(posedge clk_sys);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge clk_sys) if (rv) begin
		`CHK(rdata, rq.pop_front())
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		for (i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			d1 <= v;
			cyc(1, 0, tbps_pkg::LINE_DRIVE_CH1_ADDR, v);
			`CHK(pb_out, v[1])
			rq.push_back(v);
			cyc(0, 1, tbps_pkg::LINE_DRIVE_CH1_ADDR, 8'h00);
		end
		rq.push_back(8'h00);
		cyc(0, 1, 16'h1234, 8'h00);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			sts <= i[1];
			cyc(1, 0, tbps_pkg::IO_CONTROL_CH8_ADDR, {6'h00, i[0], 1'b0});
			rq.push_back({6'h00, i[0], 1'b0});
			cyc(0, 1, tbps_pkg::IO_CONTROL_CH8_ADDR, 8'h00);
			repeat (20) @(posedge clk_sys);
			`CHK(lbit, !(i[0] && !i[1]))
		end
		$display("test line edges done");
		b0 <= 1'b1;
		b1 <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (i = 0; i < 9; i++) begin
			@(posedge clk_sys);
			if (i > 0) begin
				`CHK(by0, d0)
				`CHK(by1, d1)
			end
			d0 <= 8'($random(seed));
			d1 <= 8'($random(seed));
		end
		`CHK(pb_oe, 1'b0)
		`CHK(lbit, 1'b0)
		b1 <= 1'b0;
		repeat (4) @(posedge clk_sys);
		`CHK(pb_oe, 1'b1)
		$display("test add buses done");
		`CHK(rq.size(), 0)
		tally_and_finish;
	end
endmodule
bind tbps_pin_share tbps_chk u_chk (.*);
